// file: inc/dual_port_consts.svh
// Purpose: Constants for the dual converter parallel input data port.
// Assumes: One system clock stands in for the converter sample clock.
// Notes: Offsets and fields of the converter control map, kept for reference.
//
// Behaviour
// - Mode zero: each channel has its own bus
// - Mode one: bus one carries interleaved I/Q
// - Dual mode: framing low powers down path
// - Single mode source sends words twice rate
// - Data clock output runs at input rate; here a capture divide of one makes it toggle at half that rate
// - Single mode: framing high to I, low Q
// - Order zero: low word then high word
// - Order one: high word then low word
// - Dual mode: both buses captured same edge
// - Data clock is copy of capture clock; divisor codes 1-3 here slow it to one rise per 2 or 4 captures
// - Data clock is sample clock over product
// - Interpolation factor 1,2,4,8 from field
// - Zero stuff factor 1 or 2 by bit
// - Port mode factor half in single mode
// - Output divisor divides only data clock
// - No interpolation: reference timed, no sync
// - Higher sample clock: source drives sync
// - Sync sampled on internal sample clock
// - Sync asserted within one sample period
// - Sync rising edge every 32 cycles; here the source raises it only when sync_req_i rises
`ifndef DUAL_PORT_CONSTS_SVH
`define DUAL_PORT_CONSTS_SVH
`define DP_REG_INTERP 8'h01
`define DP_REG_PORT 8'h02
`define DP_REG_DCLK 8'h03
`define DP_INTERP_MSB 7
`define DP_INTERP_LSB 6
`define DP_ZSTUFF_BIT 0
`define DP_MODE_BIT 6
`define DP_ORDER_BIT 0
`define DP_DIV_MSB 5
`define DP_DIV_LSB 4
`define DP_RST_MODE 1'b0
`define DP_RST_ORDER 1'b0
`define DP_RST_DIV 2'h0
`define DP_SYNC_PERIOD 32
`define DP_MAX_BUS_MSPS 300
`define DP_CLK_NS 5
`endif

// file: inc/dual_port_pkg.sv
package dual_port_pkg;
   typedef enum logic [2:0] {
      PHASE_IDLE = 3'h1,
      PHASE_LOW = 3'h2,
      PHASE_HIGH = 3'h4
   } pair_phase_t;
   typedef logic [15:0] sample_t;
endpackage : dual_port_pkg

// file: inc/dual_port_if.sv
`timescale 1ns/1ps
interface dual_port_if;
   logic data_clock_out;
   logic [15:0] port_one_bus;
   logic [15:0] port_two_bus;
   logic frame_steer_input;
   logic sync_in;
   modport device (input port_one_bus, input port_two_bus, input frame_steer_input,
      input sync_in, output data_clock_out);
   modport source (output port_one_bus, output port_two_bus, output frame_steer_input,
      output sync_in, input data_clock_out);
endinterface : dual_port_if

// file: hdl/word_fifo.sv
`timescale 1ns/1ps
// Purpose: Synchronous FIFO with valid/ready on both sides.
// Assumes: One clock; width and depth are parameters, depth a power of two.
// Notes: Ready on the write side falls when full.
module word_fifo #(
   parameter int WIDTH = 33,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Fill side
   input wire logic [WIDTH-1:0] in_data_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   // Drain side
   output logic [WIDTH-1:0] out_data_o,
   output logic out_valid_o,
   input wire logic out_ready_i
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;
   assign in_ready_o = (wr_q - rd_q) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_q != rd_q;
   assign out_data_o = mem_q[rd_q[AW-1:0]];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;
   always_ff @(posedge sys_clk_i) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data_i;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : word_fifo

// file: hdl/dual_port_device.sv
`timescale 1ns/1ps
// Purpose: Converter end of the parallel input data port.
// Assumes: sys_clk_i is the converter sample clock; data clock is a divided strobe of it.
// Notes: Captured pairs are delivered to the channels as one-cycle strobes.
module dual_port_device
   import dual_port_pkg::*;
#(
   parameter int DW = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Configuration
   input wire logic [1:0] interp_sel_i,
   input wire logic zero_stuff_i,
   input wire logic port_mode_i,
   input wire logic pair_order_i,
   input wire logic [1:0] output_clock_divisor_i,
   // Link
   dual_port_if.device link,
   // Channel outputs
   output logic [DW-1:0] chan_i_o,
   output logic [DW-1:0] chan_q_o,
   output logic chan_valid_o,
   output logic path_enabled_o,
   output logic sync_seen_o
);
   `include "dual_port_consts.svh"
   // ----------------------------------------
   // Configuration
   // ----------------------------------------
   // Mode, order and divisor code pass through flip-flops, so each follows its input one cycle later
   logic mode_q;
   logic order_q;
   logic [1:0] div_code_q;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         mode_q <= `DP_RST_MODE;
         order_q <= `DP_RST_ORDER;
         div_code_q <= `DP_RST_DIV;
      end else begin
         mode_q <= port_mode_i;
         order_q <= pair_order_i;
         div_code_q <= output_clock_divisor_i;
      end
   end
   // ----------------------------------------
   // Divisor arithmetic
   // ----------------------------------------
   // Sample clocks per capture: interpolation x zero stuffing x port factor.
   // Worked at twice the value so the half factor of single mode stays whole.
   function automatic logic [5:0] capture_div(input logic [1:0] itp, input logic stuff,
      input logic single);
      logic [6:0] v;
      v = 7'h2 << itp;
      if (stuff) v = v << 1;
      if (single) v = v >> 1;
      v = v >> 1;
      // A half-sample rate cannot be counted; one word per clock is the floor
      return (v == 7'h0) ? 6'h1 : v[5:0];
   endfunction : capture_div
   logic [5:0] cap_div;
   logic [7:0] clk_div;
   logic [7:0] cnt_q;
   logic tick;
   assign cap_div = capture_div(interp_sel_i, zero_stuff_i, mode_q);
   // Divisor codes 0,1,2 map to 1,2,4 (3 taken as 4)
   assign clk_div = {2'h0, cap_div} << (div_code_q[1] ? 2'd2 :
      {1'b0, div_code_q[0]});
   // Capture strobe never uses the output divisor
   logic [5:0] cap_cnt_q;
   assign tick = cap_cnt_q == 6'h0;
   // ----------------------------------------
   // Sync and clock generation
   // ----------------------------------------
   logic sync_q;
   logic sync_rise;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sync_q <= 1'b0;
      end else begin
         sync_q <= link.sync_in;
      end
   end
   assign sync_rise = link.sync_in && !sync_q;
   // Sync realigns both dividers so capture lands on a fixed edge
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sync_rise) begin
         cap_cnt_q <= 6'h0;
      end else if (cap_cnt_q >= cap_div - 6'h1) begin
         cap_cnt_q <= 6'h0;
      end else begin
         cap_cnt_q <= cap_cnt_q + 6'h1;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sync_rise) begin
         cnt_q <= 8'h0;
      end else if (cnt_q >= clk_div - 8'h1) begin
         cnt_q <= 8'h0;
      end else begin
         cnt_q <= cnt_q + 8'h1;
      end
   end
   logic dclk_q;
   // High for the first half; rises once every 1, 2 or 4 captures per divisor code.
   // Limitation: a divide of one can only toggle, so it runs at half rate.
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         dclk_q <= 1'b0;
      end else if (clk_div == 8'h1) begin
         dclk_q <= ~dclk_q;
      end else begin
         dclk_q <= cnt_q < (clk_div >> 1);
      end
   end
   assign link.data_clock_out = dclk_q;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sync_seen_o <= 1'b0;
      end else if (sync_rise) begin
         sync_seen_o <= 1'b1;
      end
   end
   // ----------------------------------------
   // Capture
   // ----------------------------------------
   pair_phase_t phase_q;
   logic [DW-1:0] hold_i_q;
   logic [DW-1:0] hold_q_q;
   logic frame_lvl;
   logic dual_take;
   logic pair_done;
   assign frame_lvl = link.frame_steer_input;
   // Dual mode takes both buses on one strobe, only while framing is high
   assign dual_take = !mode_q && tick && frame_lvl;
   // A pair closes on the first word whose level is opposite to its opener
   assign pair_done = mode_q && tick && ((phase_q == PHASE_LOW && frame_lvl) ||
      (phase_q == PHASE_HIGH && !frame_lvl));
   // ----------------------------------------
   // Pair tracking
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || !mode_q) begin
         phase_q <= PHASE_IDLE;
      end else if (tick) begin
         case (phase_q)
            // Opener is low when order is 0, high when order is 1
            PHASE_IDLE: begin
               if (frame_lvl == order_q) begin
                  phase_q <= frame_lvl ? PHASE_HIGH : PHASE_LOW;
               end
            end
            PHASE_LOW: begin
               if (frame_lvl) begin
                  phase_q <= PHASE_IDLE;
               end
            end
            PHASE_HIGH: begin
               if (!frame_lvl) begin
                  phase_q <= PHASE_IDLE;
               end
            end
            default: begin
               phase_q <= PHASE_IDLE;
            end
         endcase
      end
   end
   // A repeat of the opener's level just replaces the held word
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         hold_i_q <= '0;
         hold_q_q <= '0;
      end else if (mode_q && tick) begin
         if (frame_lvl) begin
            hold_i_q <= link.port_one_bus;
         end else begin
            hold_q_q <= link.port_one_bus;
         end
      end
   end
   // ----------------------------------------
   // Channel delivery
   // ----------------------------------------
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         chan_i_o <= '0;
         chan_q_o <= '0;
      end else if (dual_take) begin
         chan_i_o <= link.port_one_bus;
         chan_q_o <= link.port_two_bus;
      end else if (pair_done) begin
         chan_i_o <= frame_lvl ? link.port_one_bus : hold_i_q;
         chan_q_o <= frame_lvl ? hold_q_q : link.port_one_bus;
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         chan_valid_o <= 1'b0;
      end else begin
         chan_valid_o <= dual_take || pair_done;
      end
   end
   // Single mode needs framing for steering, so the path stays up there
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         path_enabled_o <= 1'b0;
      end else begin
         path_enabled_o <= mode_q || frame_lvl;
      end
   end
endmodule : dual_port_device

// file: hdl/dual_port_source.sv
`timescale 1ns/1ps
// Purpose: Source end: drains a sample FIFO onto the parallel port.
// Assumes: Launches on the rising edge of the data clock it receives.
// Notes: Single mode sends Q then I (or I then Q) per pair.
module dual_port_source
   import dual_port_pkg::*;
#(
   parameter int DW = 16,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Configuration
   input wire logic port_mode_i,
   input wire logic pair_order_i,
   input wire logic sync_req_i,
   // Sample stream in
   input wire logic [DW-1:0] samp_i_i,
   input wire logic [DW-1:0] samp_q_i,
   input wire logic samp_valid_i,
   output logic samp_ready_o,
   // Link
   dual_port_if.source link
);
   `include "dual_port_consts.svh"
   logic [2*DW-1:0] f_data;
   logic f_valid;
   logic f_pop;
   logic dclk_q;
   logic launch;
   logic second_q;
   logic [DW-1:0] p1_q;
   logic [DW-1:0] p2_q;
   logic fr_q;
   logic sync_q;
   word_fifo #(.WIDTH(2*DW), .DEPTH(DEPTH)) u_word_fifo (
      .sys_clk_i(sys_clk_i),
      .sys_rst_i(sys_rst_i),
      .in_data_i({samp_i_i, samp_q_i}),
      .in_valid_i(samp_valid_i),
      .in_ready_o(samp_ready_o),
      .out_data_o(f_data),
      .out_valid_o(f_valid),
      .out_ready_i(f_pop)
   );
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) dclk_q <= 1'b0;
      else dclk_q <= link.data_clock_out;
   end
   assign launch = link.data_clock_out && !dclk_q;
   // Pair popped after its second word in single mode
   assign f_pop = launch && f_valid && (!port_mode_i || second_q);
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         second_q <= 1'b0;
         p1_q <= '0;
         p2_q <= '0;
         fr_q <= 1'b0;
      end else if (launch) begin
         if (!port_mode_i) begin
            second_q <= 1'b0;
            fr_q <= f_valid;
            p1_q <= f_data[2*DW-1:DW];
            p2_q <= f_data[DW-1:0];
         end else if (f_valid) begin
            // Idle stalls the pair rather than splitting it
            second_q <= !second_q;
            fr_q <= second_q ? !pair_order_i : pair_order_i;
            p1_q <= (second_q ? !pair_order_i : pair_order_i) ?
               f_data[2*DW-1:DW] : f_data[DW-1:0];
            p2_q <= '0;
         end
      end
   end
   // Sync follows the request one sample clock later, with no alignment to launch
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) sync_q <= 1'b0;
      else sync_q <= sync_req_i;
   end
   assign link.port_one_bus = p1_q;
   assign link.port_two_bus = p2_q;
   assign link.frame_steer_input = fr_q;
   assign link.sync_in = sync_q;
endmodule : dual_port_source

// file: sim/dual_port_checker.sv
// Purpose: Concurrent checks on the link between source and device.
// Assumes: Watches the link wires plus a few device pins.
// Notes: Data clock bounds cover the slowest divided rate in use.
`timescale 1ns/1ps
module dual_port_checker (
   // Clock and reset
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   // Link and device
   input wire logic data_clock_out,
   input wire logic [15:0] port_one_bus,
   input wire logic frame_steer_input,
   input wire logic port_mode_i,
   input wire logic chan_valid_o,
   input wire logic path_enabled_o
);
   logic [2:0] rise_q;
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (sys_rst_i);
   // Recent data clock rises; the source may only launch just after one
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i)
         rise_q <= 3'h0;
      else
         rise_q <= {rise_q[1:0], $rose(data_clock_out)};
   end
   sequence dual_idle_s;
      !port_mode_i && !frame_steer_input;
   endsequence
   sequence no_valid_s;
      !chan_valid_o [*3];
   endsequence
   reset_quiet_a: assert property ($fell(sys_rst_i)
      |-> !data_clock_out && !chan_valid_o)
      else $error("outputs active after reset");
   clock_high_a: assert property ($rose(data_clock_out)
      |-> ##[1:64] $fell(data_clock_out))
      else $error("data clock stuck high");
   clock_low_a: assert property ($fell(data_clock_out)
      |-> ##[1:96] $rose(data_clock_out))
      else $error("data clock stuck low");
   launch_time_a: assert property (!$stable(port_one_bus) |-> rise_q != 3'h0)
      else $error("bus changed away from a data clock rise");
   gate_off_a: assert property (dual_idle_s |-> ##[1:2] !path_enabled_o)
      else $error("path stays enabled with framing low");
   gate_hold_a: assert property (dual_idle_s [*3] |-> !chan_valid_o)
      else $error("capture while framing low");
   dual_frame_a: assert property (!port_mode_i && chan_valid_o
      |-> $past(frame_steer_input) || $past(frame_steer_input, 2))
      else $error("dual capture without framing high");
   single_pair_a: assert property (port_mode_i && chan_valid_o |=> no_valid_s)
      else $error("pairs delivered too close");
endmodule : dual_port_checker

// file: sim/test_dual_dac_input_data_port.sv
// Purpose: Self-checking bench joining source and device over the link.
// Assumes: Both ends share mode and order settings.
// Notes: Divided data clock settings are timed only, not fed with data.
`timescale 1ns/1ps
module test_dual_dac_input_data_port;
   logic sys_clk_i, sys_rst_i, port_mode_i, pair_order_i, zero_stuff_i, sync_req_i;
   logic samp_valid_i, samp_ready_o, chan_valid_o, path_enabled_o, sync_seen_o, saw_full;
   logic [1:0] interp_sel_i, output_clock_divisor_i;
   logic [15:0] samp_i_i, samp_q_i, chan_i_o, chan_q_o;
   logic [31:0] seed, got;
   logic [31:0] exp_q[$];
   logic [6:0] cfg_tab[10] = '{7'h08, 7'h04, 7'h4C, 7'h6C, 7'h58, 7'h10, 7'h3C, 7'h09, 7'h4E,
      7'h07};
   int n_mismatch, check_count, c, k, t0, p_exp;
   logic last, pair_ok;
   dual_port_if link();
   dual_port_source u_dual_port_source (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .port_mode_i(port_mode_i), .pair_order_i(pair_order_i), .sync_req_i(sync_req_i),
      .samp_i_i(samp_i_i), .samp_q_i(samp_q_i), .samp_valid_i(samp_valid_i),
      .samp_ready_o(samp_ready_o), .link(link));
   dual_port_device u_dual_port_device (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .interp_sel_i(interp_sel_i), .zero_stuff_i(zero_stuff_i), .port_mode_i(port_mode_i),
      .pair_order_i(pair_order_i), .output_clock_divisor_i(output_clock_divisor_i),
      .link(link), .chan_i_o(chan_i_o), .chan_q_o(chan_q_o), .chan_valid_o(chan_valid_o),
      .path_enabled_o(path_enabled_o), .sync_seen_o(sync_seen_o));
   dual_port_checker u_dual_port_checker (.sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i),
      .data_clock_out(link.data_clock_out), .port_one_bus(link.port_one_bus),
      .frame_steer_input(link.frame_steer_input), .port_mode_i(port_mode_i),
      .chan_valid_o(chan_valid_o), .path_enabled_o(path_enabled_o));
   // ----
   // Helpers
   // ----
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction : xs
   function automatic int period_of(input logic [6:0] g);
      int p;
      p = (1 << g[4:3]) * (g[2] ? 2 : 1) * (g[1:0] == 2'h0 ? 1 : (g[1:0] == 2'h1 ? 2 : 4));
      return g[6] ? p / 2 : p;
   endfunction : period_of
   task summarize();
      if (n_mismatch == 0 && check_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : summarize
   task chk(input logic ok, input string msg);
      check_count++;
      if (ok !== 1'b1) begin
         n_mismatch++;
         $display("Error %0t: %s", $time, msg);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   // Valid stays up between back-to-back pushes; the caller drops it
   task push(input logic [31:0] v);
      int w;
      samp_i_i = v[31:16];
      samp_q_i = v[15:0];
      samp_valid_i = 1'b1;
      for (w = 0; w < 1000 && samp_ready_o !== 1'b1; w++) begin
         saw_full = 1'b1;
         tick(1);
      end
      if (w == 1000) begin
         chk(1'b0, "input never ready");
         summarize();
      end
      @(posedge sys_clk_i);
      exp_q.push_back(v);
      #1;
   endtask : push
   // ----
   // Model compare
   // ----
   // Sampled mid-cycle, where the one-cycle strobe and its data are settled
   always @(negedge sys_clk_i) begin
      if (sys_rst_i === 1'b0 && chan_valid_o === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk(1'b0, "unexpected pair");
         end else begin
            got = exp_q.pop_front();
            pair_ok = chan_i_o === got[31:16] && chan_q_o === got[15:0];
            chk(pair_ok, "pair data");
         end
      end
   end
   initial begin
      sys_clk_i = 1'b0;
      forever #2.5 sys_clk_i = ~sys_clk_i;
   end
   initial begin
      {sync_req_i, samp_valid_i, saw_full, samp_i_i, samp_q_i} = '0;
      n_mismatch = 0;
      check_count = 0;
      seed = 32'h00009B75;
      for (c = 0; c < 10; c++) begin
         sys_rst_i = 1'b1;
         {port_mode_i, pair_order_i, interp_sel_i, zero_stuff_i,
            output_clock_divisor_i} = cfg_tab[c];
         tick(12);
         sys_rst_i = 1'b0;
         tick(2);
         chk(sync_seen_o === 1'b0, "sync flag set after reset");
         sync_req_i = 1'b1;
         tick(1);
         sync_req_i = 1'b0;
         tick(4);
         chk(sync_seen_o === 1'b1, "sync not seen");
         t0 = -1;
         last = 1'b1;
         for (k = 0; k < 300; k++) begin
            tick(1);
            if (link.data_clock_out === 1'b1 && last === 1'b0) begin
               if (t0 >= 0)
                  break;
               t0 = k;
            end
            last = link.data_clock_out;
         end
         p_exp = period_of(cfg_tab[c]);
         chk(k - t0 == p_exp, "data clock period");
         tick(1);
         if (output_clock_divisor_i == 2'h0) begin
            for (k = 0; k < 20; k++) begin
               seed = xs(seed);
               push(seed);
            end
            samp_valid_i = 1'b0;
            for (k = 0; k < 3000 && exp_q.size() != 0; k++)
               tick(1);
            if (exp_q.size() != 0) begin
               chk(1'b0, "pairs not delivered");
               summarize();
            end
         end
      end
      chk(saw_full === 1'b1, "buffer never refused");
      summarize();
   end
endmodule : test_dual_dac_input_data_port
